// ---- rtl/kpe_keypad_port.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - pin drives latch when its direction bit is one, else it is an input
// - reset clears all direction bits, so every pin becomes an input
// - reset leaves the output latch alone
// - with read select clear, data read of an output pin returns the latch, not the pin
// - direction register reads back the value last written
// - only input pins take part in keypress detection
// - lines six and seven always detect falling edges
// - lines zero to five detect rising edge when select set, else falling
// - pull-up is off whenever rising-edge detection is selected for that line
// - a valid edge sets that line's own keypress flag
// - flags read at the data address only while read select is set
// - status flag is OR of flags; interrupt when enable set
// - interrupt reaches cpu only with enable set and cpu mask clear
// - reset clears all eight keypress flags
// - writing one to clear-all bit clears all keypress flags
// - with read select set, writing ones clears only those flags
// - input lines have pull-ups except where rising detection disables them
// - control: status bit7, enable bit6, selects 5..0, reset zero
// - status flag clears as the keypress flags clear
// - with read select clear, data write to an input pin updates latch without driving
module kpe_keypad_port (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pullup_en,
	input wire logic cpu_irq_mask,
	output logic keypad_irq
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic kpe_pkg::kpe_sel_e decode(input logic [31:0] addr);
		kpe_pkg::kpe_sel_e sel;
		sel = kpe_pkg::SEL_NONE;
		if (addr[31:10] == 22'h000000 && addr[1:0] == 2'h0) begin
			if (addr[9:2] == kpe_pkg::IDX_PORT_DATA) begin
				sel = kpe_pkg::SEL_DATA;
			end else if (addr[9:2] == kpe_pkg::IDX_DIRECTION) begin
				sel = kpe_pkg::SEL_DIR;
			end else if (addr[9:2] == kpe_pkg::IDX_KEYPAD_CONTROL) begin
				sel = kpe_pkg::SEL_KCR;
			end else if (addr[9:2] == kpe_pkg::IDX_SYSTEM_OPTIONS) begin
				sel = kpe_pkg::SEL_SOR;
			end
		end
		return sel;
	endfunction

	// ------------------------------------------------------------
	// edge helpers
	// ------------------------------------------------------------
	// lines six and seven have no select bit and stay falling-edge
	function automatic logic [7:0] rising_mask(input logic [5:0] selects);
		logic [7:0] mask;
		mask = 8'h00;
		mask[kpe_pkg::EDGE_LINES-1:0] = selects;
		return mask;
	endfunction

	// last and now differ for one cycle, so each transition counts once
	function automatic logic [7:0] edge_found(
		input logic [7:0] last,
		input logic [7:0] now,
		input logic [7:0] rise_lines
	);
		logic [7:0] up;
		logic [7:0] down;
		up = ~last & now;
		down = last & ~now;
		return (rise_lines & up) | (~rise_lines & down);
	endfunction

	function automatic logic [7:0] pullups(
		input logic [7:0] dir_bits,
		input logic [7:0] rise_lines
	);
		return ~dir_bits & ~rise_lines;
	endfunction

	// ------------------------------------------------------------
	// read helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] pin_read(
		input logic [7:0] dir_bits,
		input logic [7:0] latch_bits,
		input logic [7:0] pin_bits
	);
		return (dir_bits & latch_bits) | (~dir_bits & pin_bits);
	endfunction

	function automatic logic [7:0] control_read(
		input logic status,
		input logic enable,
		input logic [5:0] selects
	);
		logic [7:0] value;
		value = 8'h00;
		value[kpe_pkg::KCR_STATUS_BIT] = status;
		value[kpe_pkg::KCR_IRQ_ENABLE_BIT] = enable;
		value[kpe_pkg::KCR_EDGE_MSB:0] = selects;
		return value;
	endfunction

	// the clear-all bit is a strobe and always reads as zero
	function automatic logic [7:0] options_read(input logic read_select);
		logic [7:0] value;
		value = 8'h00;
		value[kpe_pkg::SOR_READ_SELECT_BIT] = read_select;
		return value;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	kpe_pkg::kpe_state_s st;
	kpe_pkg::kpe_state_s next_st;
	// the latch has no reset, so it lives outside the reset struct
	logic [7:0] port_output_latch;
	logic [7:0] next_port_output_latch;
	kpe_pkg::kpe_sample_s sample;
	logic [7:0] edge_event;
	logic [7:0] rising;
	logic [7:0] clear_mask;
	logic [7:0] pin_view;
	logic [7:0] read_byte;
	logic keypad_status_flag;
	logic addr_phase;

	kpe_pin_sampler u_sampler (
		.clock(clock),
		.rst_n(rst_n),
		.pin_in(pin_in),
		.sample(sample)
	);

	// ------------------------------------------------------------
	// edge detection
	// ------------------------------------------------------------
	assign rising = rising_mask(st.edge_polarity_selects);
	// outputs are masked so a pin turned around cannot raise a flag
	assign edge_event = edge_found(sample.prev, sample.level, rising)
		& ~st.direction;

	// derived, never stored, so it cannot disagree with the flags
	assign keypad_status_flag = |st.keypress_flags;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		pin_view = pin_read(st.direction, port_output_latch, sample.level);
		read_byte = 8'h00;
		unique case (st.sel)
			// flags and pins share the data word; read select picks which is seen
			kpe_pkg::SEL_DATA: begin
				read_byte = st.flag_read_select ? st.keypress_flags : pin_view;
			end
			kpe_pkg::SEL_DIR: begin
				read_byte = st.direction;
			end
			kpe_pkg::SEL_KCR: begin
				read_byte = control_read(keypad_status_flag, st.keypad_irq_enable,
					st.edge_polarity_selects);
			end
			kpe_pkg::SEL_SOR: begin
				read_byte = options_read(st.flag_read_select);
			end
			kpe_pkg::SEL_NONE: begin
				read_byte = 8'h00;
			end
		endcase
	end

	// hsize is ignored: every register is one whole word
	assign addr_phase = hsel && hready && htrans == kpe_pkg::HTRANS_NONSEQ;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_port_output_latch = port_output_latch;
		clear_mask = 8'h00;
		// no error responses: unmapped words read zero and ignore writes
		next_st.hresp = 1'b0;

		// writes complete in their zero-wait data phase
		if (st.bus == kpe_pkg::BUS_WRITE) begin
			unique case (st.sel)
				kpe_pkg::SEL_DATA: begin
					if (st.flag_read_select) begin
						clear_mask = hwdata[7:0];
					end else begin
						next_port_output_latch = hwdata[7:0];
					end
				end
				kpe_pkg::SEL_DIR: begin
					next_st.direction = hwdata[7:0];
				end
				kpe_pkg::SEL_KCR: begin
					next_st.keypad_irq_enable = hwdata[kpe_pkg::KCR_IRQ_ENABLE_BIT];
					next_st.edge_polarity_selects = hwdata[kpe_pkg::KCR_EDGE_MSB:0];
				end
				kpe_pkg::SEL_SOR: begin
					next_st.flag_read_select = hwdata[kpe_pkg::SOR_READ_SELECT_BIT];
					if (hwdata[kpe_pkg::SOR_CLEAR_ALL_BIT]) begin
						clear_mask = 8'hFF;
					end
				end
				kpe_pkg::SEL_NONE: begin
					clear_mask = 8'h00;
				end
			endcase
		end

		// a new edge in the clearing cycle survives
		next_st.keypress_flags = (st.keypress_flags & ~clear_mask) | edge_event;

		// reads take one wait state so a preceding write is seen
		unique case (st.bus)
			kpe_pkg::BUS_READ_WAIT: begin
				next_st.hrdata = {24'h000000, read_byte};
				next_st.hreadyout = 1'b1;
				next_st.bus = kpe_pkg::BUS_READ_DONE;
			end
			kpe_pkg::BUS_IDLE, kpe_pkg::BUS_WRITE, kpe_pkg::BUS_READ_DONE: begin
				next_st.bus = kpe_pkg::BUS_IDLE;
				if (addr_phase) begin
					next_st.sel = decode(haddr);
					if (hwrite) begin
						next_st.bus = kpe_pkg::BUS_WRITE;
					end else begin
						next_st.bus = kpe_pkg::BUS_READ_WAIT;
						next_st.hreadyout = 1'b0;
					end
				end
			end
		endcase

		next_st.pullup_en = pullups(next_st.direction,
			rising_mask(next_st.edge_polarity_selects));

		// built from next values so the request rises with its flag
		next_st.keypad_irq = (|next_st.keypress_flags) && next_st.keypad_irq_enable
			&& !cpu_irq_mask;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st.bus <= kpe_pkg::BUS_IDLE;
			st.sel <= kpe_pkg::SEL_NONE;
			st.hreadyout <= 1'b1;
			st.hresp <= 1'b0;
			st.hrdata <= kpe_pkg::RST_RDATA;
			st.direction <= kpe_pkg::RST_DIRECTION;
			st.keypress_flags <= kpe_pkg::RST_FLAGS;
			st.keypad_irq_enable <= 1'b0;
			st.edge_polarity_selects <= kpe_pkg::RST_EDGE_SELECTS;
			st.flag_read_select <= 1'b0;
			// every pin is an input with falling detection, so all pull-ups on
			st.pullup_en <= 8'hFF;
			st.keypad_irq <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// no reset term: the latch keeps its contents across reset
	always_ff @(posedge clock) begin
		port_output_latch <= next_port_output_latch;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign hreadyout = st.hreadyout;
	assign hresp = st.hresp;
	assign hrdata = st.hrdata;
	assign pin_out = port_output_latch;
	assign pin_oe = st.direction;
	assign pullup_en = st.pullup_en;
	assign keypad_irq = st.keypad_irq;

endmodule

// ---- rtl/kpe_pin_sampler.sv ----
`timescale 1ns/1ps
module kpe_pin_sampler (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] pin_in,
	output kpe_pkg::kpe_sample_s sample
);

	// ------------------------------------------------------------
	// two-flop synchroniser plus one history stage
	// ------------------------------------------------------------
	// reset to high so idle pulled-up lines show no false falling edge
	logic [7:0] meta;
	logic [7:0] level;
	logic [7:0] prev;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= kpe_pkg::RST_PIN_SAMPLE;
			level <= kpe_pkg::RST_PIN_SAMPLE;
			prev <= kpe_pkg::RST_PIN_SAMPLE;
		end else begin
			meta <= pin_in;
			level <= meta;
			prev <= level;
		end
	end

	assign sample.level = level;
	assign sample.prev = prev;

endmodule

// ---- rtl/kpe_pkg.sv ----
package kpe_pkg;

	// ------------------------------------------------------------
	// register map: printed offsets are word indices, byte = 4 * index
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_PORT_DATA = 8'h00;
	localparam logic [7:0] IDX_DIRECTION = 8'h08;
	localparam logic [7:0] IDX_KEYPAD_CONTROL = 8'h1B;
	localparam logic [7:0] IDX_SYSTEM_OPTIONS = 8'h4D;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int KCR_STATUS_BIT = 7;
	localparam int KCR_IRQ_ENABLE_BIT = 6;
	localparam int KCR_EDGE_MSB = 5;
	localparam int SOR_READ_SELECT_BIT = 2;
	localparam int SOR_CLEAR_ALL_BIT = 1;
	localparam int EDGE_LINES = 6;

	// ------------------------------------------------------------
	// reset values and the NONSEQ transfer code
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DIRECTION = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [5:0] RST_EDGE_SELECTS = 6'h00;
	localparam logic [7:0] RST_PIN_SAMPLE = 8'hFF;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_DATA,
		SEL_DIR,
		SEL_KCR,
		SEL_SOR
	} kpe_sel_e;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ_WAIT,
		BUS_READ_DONE
	} kpe_bus_e;

	typedef struct packed {
		logic [7:0] level;
		logic [7:0] prev;
	} kpe_sample_s;

	typedef struct packed {
		kpe_bus_e bus;
		kpe_sel_e sel;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic [7:0] direction;
		logic [7:0] keypress_flags;
		logic keypad_irq_enable;
		logic [5:0] edge_polarity_selects;
		logic flag_read_select;
		logic [7:0] pullup_en;
		logic keypad_irq;
	} kpe_state_s;

endpackage

// ---- sim/kpe_keypad_model.sv ----
`timescale 1ns/1ps
module kpe_keypad_model (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] key_level,
	output logic [7:0] pin_in
);
	// keys always drive; a driven output pin shows the latch instead
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & key_level);
endmodule

// ---- sim/kpe_keypad_port_properties.sv ----
`timescale 1ns/1ps
module kpe_keypad_port_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pullup_en,
	input wire logic cpu_irq_mask,
	input wire logic keypad_irq
);
	logic [7:0] kept;
	logic seen_run;
	// holds through reset, so the latch can be compared after release
	always_ff @(posedge clock) begin
		if (rst_n) begin
			kept <= pin_out;
			seen_run <= 1'b1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_dir_reset;
		$rose(rst_n) |-> pin_oe == 8'h00;
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");
	property p_latch_kept;
		$rose(rst_n) && seen_run |-> pin_out == kept;
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("latch lost in reset");
	property p_pullup_output;
		(pullup_en & pin_oe) == 8'h00;
	endproperty
	a_pullup_output: assert property (p_pullup_output) else $error("pull-up on output");
	property p_pullup_upper;
		pullup_en[7:6] == ~pin_oe[7:6];
	endproperty
	a_pullup_upper: assert property (p_pullup_upper) else $error("upper pull-up wrong");
	property p_irq_mask;
		keypad_irq |-> !$past(cpu_irq_mask);
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
	property p_data_write_only;
		$changed(pin_out) |-> $stable(pin_oe);
	endproperty
	a_data_write_only: assert property (p_data_write_only) else $error("oe moved");
	property p_dir_write_only;
		$changed(pin_oe) |-> $stable(pin_out);
	endproperty
	a_dir_write_only: assert property (p_dir_write_only) else $error("latch moved");
	property p_read_wait;
		$fell(hreadyout) |-> $past(hsel) && !$past(hwrite)
			&& $past(htrans) == kpe_pkg::HTRANS_NONSEQ;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("wait without read");
endmodule
bind kpe_keypad_port kpe_keypad_port_properties u_props (.clock(clock), .rst_n(rst_n),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .pin_out(pin_out),
	.pin_oe(pin_oe), .pullup_en(pullup_en), .cpu_irq_mask(cpu_irq_mask),
	.keypad_irq(keypad_irq));

// ---- sim/kpe_keypad_port_tb_top.sv ----
`timescale 1ns/1ps
module kpe_keypad_port_tb_top;
	localparam logic [7:0] DATA = kpe_pkg::IDX_PORT_DATA;
	localparam logic [7:0] DIR = kpe_pkg::IDX_DIRECTION;
	localparam logic [7:0] KEYPAD_CONTROL_REG = kpe_pkg::IDX_KEYPAD_CONTROL;
	localparam logic [7:0] SOR = kpe_pkg::IDX_SYSTEM_OPTIONS;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic cpu_irq_mask = 1'b0;
	logic [7:0] key_level = 8'hFF;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] pullup_en;
	logic keypad_irq;
	logic [31:0] rd;
	int num_errors = 0;
	int tests_run = 0;
	always #50 clock = ~clock;
	kpe_keypad_port dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pullup_en(pullup_en), .cpu_irq_mask(cpu_irq_mask),
		.keypad_irq(keypad_irq));
	kpe_keypad_model keys (.pin_out(pin_out), .pin_oe(pin_oe), .key_level(key_level),
		.pin_in(pin_in));
	task summarize;
		$display("checks %0d, errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 40);
		if (hready !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: no ready from the bus", $time);
			summarize();
		end
	endtask
	task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		htrans <= kpe_pkg::HTRANS_NONSEQ;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_ready();
		rd = hrdata;
		check(32'(hresp), 32'h0);
	endtask
	task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 8'h00);
		check(rd, exp);
	endtask
	// detection needs two sync stages, a compare and the irq register
	task pause;
		repeat (5) @(posedge clock);
	endtask
	task t_reset_values;
		rd_chk(DIR, 32'h0);
		rd_chk(KEYPAD_CONTROL_REG, 32'h0);
		rd_chk(8'h01, 32'h0);
		check(32'(pullup_en), 32'hFF);
		$display("test reset_values done");
	endtask
	task t_direction;
		xfer(1'b1, DATA, 8'hA5);
		@(posedge clock);
		check(32'({pin_oe, pin_out}), 32'h00A5);
		xfer(1'b1, DIR, 8'h0F);
		rd_chk(DIR, 32'h0F);
		check(32'(pin_oe), 32'h0F);
		key_level <= 8'hF0;
		pause();
		rd_chk(DATA, 32'hF5);
		key_level <= 8'hFF;
		xfer(1'b1, DIR, 8'h00);
		xfer(1'b1, SOR, 8'h04);
		rd_chk(DATA, 32'h0);
		$display("test direction done");
	endtask
	task t_edges;
		xfer(1'b1, KEYPAD_CONTROL_REG, 8'h41);
		@(posedge clock);
		check(32'(pullup_en), 32'hFE);
		key_level <= 8'hFE;
		pause();
		key_level <= 8'hFF;
		pause();
		rd_chk(DATA, 32'h01);
		check(32'(keypad_irq), 32'h1);
		rd_chk(KEYPAD_CONTROL_REG, 32'hC1);
		key_level <= 8'h7F;
		pause();
		rd_chk(DATA, 32'h81);
		cpu_irq_mask <= 1'b1;
		pause();
		check(32'(keypad_irq), 32'h0);
		cpu_irq_mask <= 1'b0;
		$display("test edges done");
	endtask
	task t_clear;
		xfer(1'b1, DATA, 8'h01);
		rd_chk(DATA, 32'h80);
		check(32'(pin_out), 32'hA5);
		xfer(1'b1, SOR, 8'h06);
		rd_chk(DATA, 32'h0);
		rd_chk(SOR, 32'h04);
		rd_chk(KEYPAD_CONTROL_REG, 32'h41);
		check(32'(keypad_irq), 32'h0);
		$display("test clear done");
	endtask
	task t_rerun_reset;
		key_level <= 8'hFF;
		pause();
		key_level <= 8'h7F;
		pause();
		key_level <= 8'hFF;
		xfer(1'b1, DIR, 8'h30);
		pause();
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check(32'({pin_oe, pin_out}), 32'h00A5);
		xfer(1'b1, SOR, 8'h04);
		rd_chk(DATA, 32'h0);
		$display("test rerun_reset done");
	endtask
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset_values();
		t_direction();
		t_edges();
		t_clear();
		t_rerun_reset();
		summarize();
	end
endmodule
